// *** rifc_regs.vh ***
`ifndef RIFC_REGS_VH
`define RIFC_REGS_VH
// register indexes on the register port
`define RIFC_ENABLE_ADDR 8'h3F
`define RIFC_CTL_ADDR 8'h41
`define RIFC_CLEAR_ADDR 8'h42
`define RIFC_FLAGS_ADDR 8'h43
// bit positions shared by enable, clear and flag registers
`define RIFC_BIT_SLEEP_TMO 7
`define RIFC_BIT_RX_TMO 6
`define RIFC_BIT_STRENGTH 5
`define RIFC_BIT_PREAMBLE 4
`define RIFC_BIT_SYNCWORD 3
`define RIFC_BIT_NODE 2
`define RIFC_BIT_CHECKSUM 1
`define RIFC_BIT_PKT_END 0
// selector fields of the routing register
`define RIFC_SEL_TWO_MSB 7
`define RIFC_SEL_TWO_LSB 4
`define RIFC_SEL_ONE_MSB 3
`define RIFC_SEL_ONE_LSB 0
// reset values
`define RIFC_ENABLE_RST 8'h00
`define RIFC_CTL_RST 8'h00
`define RIFC_FLAGS_RST 8'h00
// data modes
`define RIFC_MODE_DIRECT 2'h0
`define RIFC_MODE_BUFFER 2'h1
`define RIFC_MODE_PACKET 2'h2
// operating states; all but sleep accept clear writes
`define RIFC_ST_SLEEP 3'h0
`define RIFC_ST_STANDBY 3'h1
`define RIFC_ST_TUNE 3'h2
`define RIFC_ST_RECEIVE 3'h3
`define RIFC_ST_EEPROM 3'h4
`endif

// *** rifc_irq_route.v ***
`timescale 1ns/1ps
`include "rifc_regs.vh"
module rifc_irq_route (
	input wire [3:0] sel,
	input wire [1:0] dataMode,
	input wire [7:0] flags,
	input wire [4:0] fifoStatus,
	output reg irqLevel
);
	// fifoStatus: {overflow, writeByte, full, threshold, notEmpty}
	always @* begin
		irqLevel = 1'b0;
		if (dataMode == `RIFC_MODE_PACKET) begin
			case (sel)
				4'h1: irqLevel = flags[`RIFC_BIT_STRENGTH];
				4'h2: irqLevel = flags[`RIFC_BIT_PREAMBLE];
				4'h3: irqLevel = flags[`RIFC_BIT_SYNCWORD];
				4'h4: irqLevel = flags[`RIFC_BIT_NODE];
				4'h5: irqLevel = flags[`RIFC_BIT_CHECKSUM];
				4'h6: irqLevel = flags[`RIFC_BIT_PKT_END];
				4'h7: irqLevel = flags[`RIFC_BIT_SLEEP_TMO];
				4'h8: irqLevel = flags[`RIFC_BIT_RX_TMO];
				4'h9: irqLevel = fifoStatus[0];
				4'hA: irqLevel = fifoStatus[1];
				4'hB: irqLevel = fifoStatus[2];
				4'hC: irqLevel = fifoStatus[3];
				4'hD: irqLevel = fifoStatus[4];
				default: irqLevel = 1'b0;
			endcase
		end else begin
			case (sel)
				4'h1: irqLevel = flags[`RIFC_BIT_STRENGTH];
				4'h2: irqLevel = flags[`RIFC_BIT_PREAMBLE];
				4'h3: irqLevel = flags[`RIFC_BIT_SYNCWORD];
				4'h4: irqLevel = flags[`RIFC_BIT_SLEEP_TMO];
				4'h5: irqLevel = flags[`RIFC_BIT_RX_TMO];
				4'h6: irqLevel = (dataMode == `RIFC_MODE_BUFFER) ? fifoStatus[0] : 1'b0;
				4'h7: irqLevel = (dataMode == `RIFC_MODE_BUFFER) ? fifoStatus[1] : 1'b0;
				4'h8: irqLevel = (dataMode == `RIFC_MODE_BUFFER) ? fifoStatus[2] : 1'b0;
				4'h9: irqLevel = (dataMode == `RIFC_MODE_BUFFER) ? fifoStatus[3] : 1'b0;
				4'hA: irqLevel = (dataMode == `RIFC_MODE_BUFFER) ? fifoStatus[4] : 1'b0;
				default: irqLevel = 1'b0;
			endcase
		end
	end
endmodule // rifc_irq_route

// *** rifc_flag_clear.v ***
`timescale 1ns/1ps
`include "rifc_regs.vh"
module rifc_flag_clear #(
	parameter NUM_EVENTS = 8
) (
	input wire clock,
	input wire rst_b,
	input wire regWrite,
	input wire regRead,
	input wire [7:0] regAddr,
	input wire [7:0] regWrData,
	output reg [7:0] regRdData_q,
	input wire [2:0] opState,
	input wire [1:0] dataMode,
	input wire fskDemod,
	input wire sleepTimerOn,
	input wire sleepTimerExpire,
	input wire rxTimerOn,
	input wire rxTimerExpire,
	input wire strengthAboveThresh,
	input wire preambleValid,
	input wire syncwordDetect,
	input wire nodeMatch,
	input wire checksumGood,
	input wire packetEnd,
	input wire [4:0] fifoStatus,
	output reg irqOutOne_q,
	output reg irqOutTwo_q
);
	// register state and next values
	reg [7:0] enable_q;
	reg [7:0] enable_d;
	reg [7:0] routeCtl_q;
	reg [7:0] routeCtl_d;
	reg [NUM_EVENTS-1:0] flags_q;
	wire [NUM_EVENTS-1:0] flags_d;
	reg [7:0] regRdData_d;

	// decode of the register port and of the event sources
	reg clearAllowed;
	reg [NUM_EVENTS-1:0] rawEvent;
	wire packetMode;
	wire clearWrite;
	wire enableWrite;
	wire routeWrite;
	wire [NUM_EVENTS-1:0] setMask;
	wire [NUM_EVENTS-1:0] clearMask;
	wire sleepTimeoutHit;
	wire receiveTimeoutHit;
	wire strengthValidHit;
	wire preamblePassHit;
	wire syncwordPassHit;
	wire nodeMatchHit;
	wire checksumPassHit;
	wire packetEndHit;

	// interrupt routing
	wire [3:0] selOne;
	wire [3:0] selTwo;
	wire irqOneLevel;
	wire irqTwoLevel;

	assign enableWrite = regWrite && (regAddr == `RIFC_ENABLE_ADDR);
	assign routeWrite = regWrite && (regAddr == `RIFC_CTL_ADDR);

	// outside these states the write reaches nothing, so a sleeping part keeps its flags
	always @* begin
		case (opState)
			`RIFC_ST_STANDBY: clearAllowed = 1'b1;
			`RIFC_ST_TUNE: clearAllowed = 1'b1;
			`RIFC_ST_RECEIVE: clearAllowed = 1'b1;
			`RIFC_ST_EEPROM: clearAllowed = 1'b1;
			default: clearAllowed = 1'b0;
		endcase
	end
	assign clearWrite = regWrite && (regAddr == `RIFC_CLEAR_ADDR) && clearAllowed;

	// each source except preamble and syncword only counts under the condition its flag is defined for
	assign packetMode = (dataMode == `RIFC_MODE_PACKET);
	assign sleepTimeoutHit = sleepTimerOn && sleepTimerExpire;
	assign receiveTimeoutHit = rxTimerOn && rxTimerExpire;
	assign strengthValidHit = fskDemod && strengthAboveThresh;
	assign preamblePassHit = preambleValid;
	assign syncwordPassHit = syncwordDetect;
	assign nodeMatchHit = packetMode && nodeMatch;
	assign checksumPassHit = packetMode && checksumGood;
	// a failed node or checksum test still ends the packet, so packet end ignores both
	assign packetEndHit = packetMode && packetEnd;

	// bit n of the event vector lines up with bit n of enable, clear and flags
	always @* begin
		rawEvent = {NUM_EVENTS{1'b0}};
		rawEvent[`RIFC_BIT_SLEEP_TMO] = sleepTimeoutHit;
		rawEvent[`RIFC_BIT_RX_TMO] = receiveTimeoutHit;
		rawEvent[`RIFC_BIT_STRENGTH] = strengthValidHit;
		rawEvent[`RIFC_BIT_PREAMBLE] = preamblePassHit;
		rawEvent[`RIFC_BIT_SYNCWORD] = syncwordPassHit;
		rawEvent[`RIFC_BIT_NODE] = nodeMatchHit;
		rawEvent[`RIFC_BIT_CHECKSUM] = checksumPassHit;
		rawEvent[`RIFC_BIT_PKT_END] = packetEndHit;
	end

	// enable is looked at only at event time; dropping it later leaves a set flag alone
	assign setMask = rawEvent & enable_q[NUM_EVENTS-1:0];
	assign clearMask = clearWrite ? regWrData[NUM_EVENTS-1:0] : {NUM_EVENTS{1'b0}};

	genvar i;
	generate
		for (i = 0; i < NUM_EVENTS; i = i + 1) begin : gFlag
			// a new event wins over a clear in the same cycle, so no event is lost
			assign flags_d[i] = setMask[i] |
				(flags_q[i] & ~clearMask[i]);
		end
	endgenerate

	always @(posedge clock) begin
		if (!rst_b) begin
			flags_q <= `RIFC_FLAGS_RST;
		end else begin
			flags_q <= flags_d;
		end
	end

	always @* begin
		enable_d = enable_q;
		if (enableWrite) begin
			enable_d = regWrData;
		end
	end

	always @(posedge clock) begin
		if (!rst_b) begin
			enable_q <= `RIFC_ENABLE_RST;
		end else begin
			enable_q <= enable_d;
		end
	end

	always @* begin
		routeCtl_d = routeCtl_q;
		if (routeWrite) begin
			routeCtl_d = regWrData;
		end
	end

	always @(posedge clock) begin
		if (!rst_b) begin
			routeCtl_q <= `RIFC_CTL_RST;
		end else begin
			routeCtl_q <= routeCtl_d;
		end
	end

	// clear register is write-only and reads back as zero, as does any unmapped index
	always @* begin
		regRdData_d = regRdData_q;
		if (regRead) begin
			case (regAddr)
				`RIFC_ENABLE_ADDR: regRdData_d = enable_q;
				`RIFC_CTL_ADDR: regRdData_d = routeCtl_q;
				`RIFC_FLAGS_ADDR: regRdData_d = flags_q;
				default: regRdData_d = 8'h00;
			endcase
		end
	end

	always @(posedge clock) begin
		if (!rst_b) begin
			regRdData_q <= 8'h00;
		end else begin
			regRdData_q <= regRdData_d;
		end
	end

	assign selOne = routeCtl_q[`RIFC_SEL_ONE_MSB:`RIFC_SEL_ONE_LSB];
	assign selTwo = routeCtl_q[`RIFC_SEL_TWO_MSB:`RIFC_SEL_TWO_LSB];

	// both outputs share one mapping, so one decoder serves each; fifo levels only pass through
	rifc_irq_route uRouteOne (
		.sel(selOne),
		.dataMode(dataMode),
		.flags(flags_q),
		.fifoStatus(fifoStatus),
		.irqLevel(irqOneLevel)
	);

	rifc_irq_route uRouteTwo (
		.sel(selTwo),
		.dataMode(dataMode),
		.flags(flags_q),
		.fifoStatus(fifoStatus),
		.irqLevel(irqTwoLevel)
	);

	// registered so the pins never glitch while a selector changes
	always @(posedge clock) begin
		if (!rst_b) begin
			irqOutOne_q <= 1'b0;
		end else begin
			irqOutOne_q <= irqOneLevel;
		end
	end

	always @(posedge clock) begin
		if (!rst_b) begin
			irqOutTwo_q <= 1'b0;
		end else begin
			irqOutTwo_q <= irqTwoLevel;
		end
	end
endmodule // rifc_flag_clear

// *** rifc_flag_clear_sva.sv ***
`timescale 1ns/1ps
module rifc_flag_clear_sva (
	input wire clock,
	input wire rst_b,
	input wire regWrite,
	input wire regRead,
	input wire [7:0] regAddr,
	input wire [7:0] regWrData,
	input wire [7:0] regRdData_q,
	input wire [2:0] opState,
	input wire [1:0] dataMode,
	input wire fskDemod,
	input wire sleepTimerOn,
	input wire sleepTimerExpire,
	input wire rxTimerOn,
	input wire rxTimerExpire,
	input wire strengthAboveThresh,
	input wire preambleValid,
	input wire syncwordDetect,
	input wire nodeMatch,
	input wire checksumGood,
	input wire packetEnd,
	input wire irqOutOne_q,
	input wire irqOutTwo_q
);
	reg [7:0] en_q, rt_q, fl_q;
	wire pk = dataMode == 2'h2;
	wire [7:0] hit = en_q & {sleepTimerOn & sleepTimerExpire, rxTimerOn & rxTimerExpire,
		fskDemod & strengthAboveThresh, preambleValid, syncwordDetect,
		pk & nodeMatch, pk & checksumGood, pk & packetEnd};
	wire clrOk = regWrite && regAddr == 8'h42 && opState != 3'h0 && opState < 3'h5;
	// an event on the clearing edge wins, so hit is or-ed in last
	always @(posedge clock) begin
		if (!rst_b) begin
			en_q <= 8'h00;
			rt_q <= 8'h00;
			fl_q <= 8'h00;
		end else begin
			if (regWrite && regAddr == 8'h3f) en_q <= regWrData;
			if (regWrite && regAddr == 8'h41) rt_q <= regWrData;
			fl_q <= (fl_q & ~(clrOk ? regWrData : 8'h00)) | hit;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	a_flags_read_back: assert property (regRead && regAddr == 8'h43 |=>
		regRdData_q == $past(fl_q)) else $error("flag read mismatch");
	a_enable_read_back: assert property (regRead && regAddr == 8'h3f |=>
		regRdData_q == $past(en_q)) else $error("enable read mismatch");
	a_route_read_back: assert property (regRead && regAddr == 8'h41 |=>
		regRdData_q == $past(rt_q)) else $error("routing read mismatch");
	a_clear_reads_zero: assert property (regRead && regAddr == 8'h42 |=>
		regRdData_q == 8'h00) else $error("clear register not zero");
	a_one_off_low: assert property (rt_q[3:0] == 4'h0 |=> !irqOutOne_q)
		else $error("output one high while off");
	a_two_off_low: assert property (rt_q[7:4] == 4'h0 |=> !irqOutTwo_q)
		else $error("output two high while off");
	a_one_sync_route: assert property (rt_q[3:0] == 4'h3 |=>
		irqOutOne_q == $past(fl_q[3])) else $error("output one not sync flag");
	a_two_rssi_route: assert property (rt_q[7:4] == 4'h1 |=>
		irqOutTwo_q == $past(fl_q[5])) else $error("output two not strength flag");
endmodule // rifc_flag_clear_sva
bind rifc_flag_clear rifc_flag_clear_sva rifc_flag_clear_sva_inst (
	.clock(clock),
	.rst_b(rst_b),
	.regWrite(regWrite),
	.regRead(regRead),
	.regAddr(regAddr),
	.regWrData(regWrData),
	.regRdData_q(regRdData_q),
	.opState(opState),
	.dataMode(dataMode),
	.fskDemod(fskDemod),
	.sleepTimerOn(sleepTimerOn),
	.sleepTimerExpire(sleepTimerExpire),
	.rxTimerOn(rxTimerOn),
	.rxTimerExpire(rxTimerExpire),
	.strengthAboveThresh(strengthAboveThresh),
	.preambleValid(preambleValid),
	.syncwordDetect(syncwordDetect),
	.nodeMatch(nodeMatch),
	.checksumGood(checksumGood),
	.packetEnd(packetEnd),
	.irqOutOne_q(irqOutOne_q),
	.irqOutTwo_q(irqOutTwo_q)
);

// *** rifc_host_model.sv ***
`timescale 1ns/1ps
module rifc_host_model (
	input wire clock,
	input wire [7:0] regRdData_q,
	output reg regWrite,
	output reg regRead,
	output reg [7:0] regAddr,
	output reg [7:0] regWrData
);
	initial {regWrite, regRead, regAddr, regWrData} = 18'h0_0000;
	// entered just after an edge; the access is taken at the next one
	task acc(input w, input [7:0] a, input [7:0] d, output [7:0] q);
		begin
			regWrite <= w;
			regRead <= !w;
			regAddr <= a;
			regWrData <= d;
			@(posedge clock);
			regWrite <= 1'b0;
			regRead <= 1'b0;
			@(posedge clock);
			q = regRdData_q;
		end
	endtask
endmodule // rifc_host_model

// *** test_rifc_flag_clear.sv ***
`timescale 1ns/1ps
module test_rifc_flag_clear;
	reg clock = 1'b0;
	reg rst_b = 1'b0;
	reg [2:0] opState = 3'h1;
	reg [1:0] dataMode = 2'h2;
	reg gateOn = 1'b1;
	reg [7:0] ev = 8'h00;
	reg [4:0] fifoSt = 5'h00;
	reg [7:0] q;
	reg [7:0] fl;
	wire regWrite, regRead, irqOutOne_q, irqOutTwo_q;
	wire [7:0] regAddr, regWrData, regRdData_q;
	integer n_errors = 0;
	integer samples_checked = 0;
	integer i;
	initial forever #20 clock = ~clock;
	rifc_host_model rifc_host_model_inst (.clock(clock), .regRdData_q(regRdData_q),
		.regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData));
	rifc_flag_clear rifc_flag_clear_inst (.clock(clock), .rst_b(rst_b), .regWrite(regWrite),
		.regRead(regRead), .regAddr(regAddr), .regWrData(regWrData), .regRdData_q(regRdData_q),
		.opState(opState), .dataMode(dataMode), .fskDemod(gateOn), .sleepTimerOn(gateOn),
		.sleepTimerExpire(ev[7]), .rxTimerOn(gateOn), .rxTimerExpire(ev[6]),
		.strengthAboveThresh(ev[5]), .preambleValid(ev[4]), .syncwordDetect(ev[3]),
		.nodeMatch(ev[2]), .checksumGood(ev[1]), .packetEnd(ev[0]), .fifoStatus(fifoSt),
		.irqOutOne_q(irqOutOne_q), .irqOutTwo_q(irqOutTwo_q));
	task chk(input [7:0] got, input [7:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("Error at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task rd(input [7:0] a, input [7:0] exp);
		begin
			rifc_host_model_inst.acc(1'b0, a, 8'h00, q);
			chk(q, exp);
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		rifc_host_model_inst.acc(1'b1, a, d, q);
	endtask
	task pulse(input [7:0] e);
		begin
			ev <= e;
			@(posedge clock);
			ev <= 8'h00;
			@(posedge clock);
		end
	endtask
	task reg_test;
		begin
			rd(8'h3f, 8'h00);
			rd(8'h41, 8'h00);
			wr(8'h3f, 8'hff);
			rd(8'h3f, 8'hff);
			wr(8'h43, 8'hff);
			rd(8'h43, 8'h00);
			rd(8'h42, 8'h00);
			rd(8'h50, 8'h00);
		end
	endtask
	task event_test;
		begin
			fl = 8'h00;
			for (i = 0; i < 8; i = i + 1) begin
				pulse(8'h01 << i);
				fl = fl | (8'h01 << i);
				rd(8'h43, fl);
			end
			gateOn <= 1'b0;
			dataMode <= 2'h0;
			wr(8'h42, 8'hff);
			rd(8'h43, 8'h00);
			pulse(8'hff);
			rd(8'h43, 8'h18);
			gateOn <= 1'b1;
			dataMode <= 2'h2;
		end
	endtask
	task clear_test;
		begin
			pulse(8'hff);
			opState <= 3'h0;
			wr(8'h42, 8'hff);
			rd(8'h43, 8'hff);
			opState <= 3'h5;
			wr(8'h42, 8'hff);
			rd(8'h43, 8'hff);
			for (i = 1; i < 5; i = i + 1) begin
				opState <= i[2:0];
				wr(8'h42, 8'h80 >> (i - 1));
				rd(8'h43, 8'hff >> i);
			end
			wr(8'h3f, 8'h00);
			wr(8'h42, 8'hff);
			pulse(8'hff);
			rd(8'h43, 8'h00);
		end
	endtask
	task irq_test;
		begin
			wr(8'h3f, 8'hff);
			wr(8'h41, 8'h13);
			pulse(8'h08);
			@(posedge clock);
			chk({7'h00, irqOutOne_q}, 8'h01);
			chk({7'h00, irqOutTwo_q}, 8'h00);
			wr(8'h42, 8'h08);
			@(posedge clock);
			chk({7'h00, irqOutOne_q}, 8'h00);
			// event and clear on the same edge: the event must win
			fork
				wr(8'h42, 8'h08);
				pulse(8'h08);
			join
			rd(8'h43, 8'h08);
			// one on selector 6, two on selector 4, whose sources depend on the data mode
			fifoSt <= 5'h01;
			wr(8'h41, 8'h46);
			pulse(8'h80);
			@(posedge clock);
			chk({6'h00, irqOutTwo_q, irqOutOne_q}, 8'h00);
			dataMode <= 2'h1;
			repeat (2) @(posedge clock);
			chk({6'h00, irqOutTwo_q, irqOutOne_q}, 8'h03);
			dataMode <= 2'h0;
			repeat (2) @(posedge clock);
			chk({6'h00, irqOutTwo_q, irqOutOne_q}, 8'h02);
		end
	endtask
	task reset_test;
		begin
			rst_b <= 1'b0;
			repeat (2) @(posedge clock);
			rst_b <= 1'b1;
			@(posedge clock);
			chk({6'h00, irqOutTwo_q, irqOutOne_q}, 8'h00);
			rd(8'h43, 8'h00);
			rd(8'h41, 8'h00);
			rd(8'h3f, 8'h00);
			dataMode <= 2'h2;
			fifoSt <= 5'h00;
		end
	endtask
	task final_report;
		begin
			$display("errors %0d checks %0d", n_errors, samples_checked);
			if (n_errors == 0 && samples_checked > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	initial begin
		repeat (20) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		reg_test;
		event_test;
		clear_test;
		irq_test;
		reset_test;
		final_report;
	end
	// the tests need under 150 cycles; allow over fifteen times that
	initial begin
		#100000;
		n_errors = n_errors + 1;
		final_report;
	end
endmodule // test_rifc_flag_clear
